// file: dv/flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
   parameter int BUF_MAX = 512
) (
   input wire logic clk_sys_i,
   input wire logic [23:0] addr_i,
   input wire logic [15:0] dq_i,
   output logic [15:0] dq_o,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic rst_n_i,
   input wire logic hv_i
);
   localparam int RD = 0, SET = 1, LD = 2, PRG = 3, ABT = 4, SUS = 5, ERS = 6;
   localparam int CHIP = 7, BLK = 8, RUN = 9;
   int st = RD;
   int cnt = 0;
   int tmr = 0;
   int uc = 0;
   logic [14:0] pg = 15'h0;
   logic we_q = 1'b1;
   logic oe_q = 1'b1;
   logic tog = 1'b0;
   logic [15:0] last = 16'h0;
   logic [15:0] q = 16'h0;
   logic [15:0] word;
   always_comb begin
      word = {8'h00, ~last[7], tog, 2'b00, st == RUN || st == CHIP, 1'b0, st == ABT, 1'b0};
      if (st == RD || st == SUS || st == SET || st == LD) word = 16'h0;
      dq_o = (ce_n_i || oe_n_i) ? ~q : word;
   end
   always @(posedge clk_sys_i) begin
      we_q <= we_n_i;
      oe_q <= oe_n_i;
      q <= dq_o;
      if (!oe_n_i && oe_q) tog <= ~tog;
      if (tmr > 0 && st != SUS) tmr <= tmr - 1;
      if (!rst_n_i) begin
         st <= RD;
         tmr <= 0;
      end else if (tmr == 1 && st == BLK) begin
         st <= RUN;
         tmr <= 100;
      end else if (tmr == 1 && st != SUS) st <= RD;
      else if (we_n_i && !we_q) begin
         last <= dq_i;
         uc <= (dq_i == 16'h00aa || dq_i == 16'h0055) ? uc + 1 : 0;
         case (st)
            RD: if (dq_i == 16'h0025 && (uc == 2 || hv_i)) begin
                  st <= SET;
                  pg <= addr_i[23:9];
               end else if (dq_i == 16'h0080) st <= ERS;
            SET: begin
               cnt <= dq_i + 1;
               st <= (dq_i + 1 > BUF_MAX) ? ABT : LD;
            end
            LD: if (cnt > 0) begin
                  cnt <= cnt - 1;
                  if (addr_i[23:9] != pg) st <= ABT;
               end else if (dq_i == 16'h0029) begin
                  st <= PRG;
                  tmr <= 300;
               end else st <= ABT;
            PRG: if (dq_i == 16'h00b0) st <= SUS;
            SUS: if (dq_i == 16'h0030) st <= PRG;
            ABT: if (dq_i == 16'h00f0 && uc == 2) st <= RD;
            ERS: if (dq_i == 16'h0010) begin
                  st <= CHIP;
                  tmr <= 300;
               end else if (dq_i == 16'h0030) begin
                  st <= BLK;
                  tmr <= 200;
               end
            BLK: if (dq_i == 16'h0030) tmr <= 200;
               else if (dq_i != 16'h00b0) begin
                  st <= RD;
                  tmr <= 0;
               end
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: dv/nor_host_props.sv
`timescale 1ns/1ps
`default_nettype none
module nor_host_props #(
   parameter int RST_CYCLES = 4
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic [23:0] flash_addr_o,
   input wire logic [15:0] flash_dq_o,
   input wire logic flash_dq_oe_o,
   input wire logic flash_ce_n_o,
   input wire logic flash_oe_n_o,
   input wire logic flash_we_n_o,
   input wire logic flash_rst_n_o
);
   int rcnt;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) rcnt <= 0;
      else rcnt <= flash_rst_n_o ? 0 : rcnt + 1;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_low8;
      !flash_we_n_o [*8];
   endsequence
   sequence s_strobe;
      s_low8 ##1 !flash_we_n_o [*4] ##1 flash_we_n_o;
   endsequence
   AST_ONE_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o) else $error("late waitrequest");
   AST_NOT_BOTH: assert property (flash_oe_n_o || flash_we_n_o)
      else $error("both strobes low");
   AST_WE_WIDTH: assert property ($fell(flash_we_n_o) |-> s_strobe)
      else $error("strobe width");
   AST_CE_HOLD: assert property (!flash_we_n_o || !flash_oe_n_o |-> !flash_ce_n_o)
      else $error("strobe without ce_n");
   AST_DRIVE_WR: assert property (!flash_we_n_o |-> flash_dq_oe_o)
      else $error("write data not driven");
   AST_NO_DRIVE_RD: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
      else $error("dq driven on read");
   AST_WR_STABLE: assert property (!flash_we_n_o && !$past(flash_we_n_o) |->
      $stable(flash_dq_o) && $stable(flash_addr_o)) else $error("write cycle changed");
   AST_RST_LEN: assert property ($rose(flash_rst_n_o) |-> rcnt == RST_CYCLES)
      else $error("reset pulse length");
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import nor_host_pkg::*;
   localparam int BUF = 16;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat, rv;
   logic wait_o, oe, ce_n, oe_n, we_n, frst_n, hv;
   logic [23:0] fa;
   logic [15:0] fdo, mdq;
   logic we_d = 1'b1;
   int fails = 0;
   int checks = 0;
   int wes = 0;
   int w0;
   always #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      we_d <= we_n;
      if (we_d && !we_n) wes <= wes + 1;
   end
   nor_host_ctrl #(.RST_CYCLES(4), .BUF_MAX(BUF)) DUT (.clk_sys_i, .rst_i,
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .flash_addr_o(fa), .flash_dq_o(fdo),
      .flash_dq_oe_o(oe), .flash_dq_i(oe ? fdo : mdq), .flash_ce_n_o(ce_n),
      .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_rst_n_o(frst_n),
      .high_voltage_level_o(hv));
   flash_model #(.BUF_MAX(BUF)) u_flash (.clk_sys_i, .addr_i(fa), .dq_i(fdo),
      .dq_o(mdq), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .rst_n_i(frst_n), .hv_i(hv));
   task automatic end_sim;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] r, input logic [31:0] d);
      int n = 0;
      @(posedge clk_sys_i);
      adr <= {r, 2'b00};
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (wait_o !== 1'b0 && n < 50);
      if (wait_o !== 1'b0) fails++;
      rv = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic op(input op_e o, input logic [31:0] a, input logic [31:0] d);
      int n;
      bus(1'b1, REG_ADDR, a);
      bus(1'b1, REG_DATA, d);
      bus(1'b1, REG_CTRL, {28'h0, o});
      n = 0;
      do begin
         bus(1'b0, REG_STATUS, 32'h0);
         n++;
      end while (rv[0] !== 1'b0 && n < 400);
      if (rv[0] !== 1'b0) fails++;
   endtask
   task automatic poll(input int bit_n, input logic v);
      int n = 0;
      do begin
         op(OP_POLL, 32'h0, 32'h0);
         n++;
      end while (rv[bit_n] !== v && n < 30);
      if (rv[bit_n] !== v) fails++;
   endtask
   task automatic t_abort;
      bus(1'b1, REG_MODE, 32'h1);
      chk("hv pin", hv, 1);
      op(OP_WBUF_SETUP, 32'h200, BUF);
      chk("refused", rv[8], 1);
      op(OP_WRITE, 32'h200, 32'h25);
      op(OP_WRITE, 32'h200, BUF);
      op(OP_POLL, 32'h200, 32'h0);
      chk("aborted", rv[1], 1);
      chk("abort bits", rv[6:5], 2'b01);
      w0 = wes;
      op(OP_ABORT_RESET, 32'h0, 32'h0);
      chk("abort reset writes", wes - w0, 3);
      poll(4, 1'b0);
      chk("recovered", rv[1], 0);
      bus(1'b1, REG_MODE, 32'h0);
   endtask
   task automatic t_susp;
      op(OP_WBUF_SETUP, 32'h400, 32'h0);
      op(OP_WBUF_LOAD, 32'h400, 32'h5a5a);
      op(OP_WBUF_CONFIRM, 32'h400, 32'h0);
      op(OP_SUSPEND, 32'h0, 32'h0);
      chk("suspended", rv[2], 1);
      op(OP_RESUME, 32'h0, 32'h0);
      chk("resumed", rv[2], 0);
      op(OP_SUSPEND, 32'h0, 32'h0);
      chk("suspended again", rv[2], 1);
      op(OP_RESUME, 32'h0, 32'h0);
      poll(4, 1'b0);
      chk("program done", rv[6], 0);
   endtask
   task automatic t_chip(input logic [31:0] mode, input int n);
      bus(1'b1, REG_MODE, mode);
      w0 = wes;
      op(OP_CHIP_ERASE, 32'h0, 32'h0);
      chk("chip erase writes", wes - w0, n);
      op(OP_POLL, 32'h0, 32'h0);
      chk("chip erase busy", rv[4], 1);
      poll(4, 1'b0);
      chk("chip erase ended", rv[9], 0);
      bus(1'b1, REG_MODE, 32'h0);
   endtask
   task automatic t_block;
      w0 = wes;
      op(OP_BLOCK_ERASE, 32'h10000, 32'h0);
      chk("block erase writes", wes - w0, 6);
      op(OP_POLL, 32'h10000, 32'h0);
      chk("timer open", rv[7], 0);
      w0 = wes;
      op(OP_BLOCK_ADD, 32'h20000, 32'h0);
      chk("block add writes", wes - w0, 1);
      poll(7, 1'b1);
      chk("timer expired", rv[7], 1);
      poll(4, 1'b0);
      op(OP_BLOCK_ERASE, 32'h10000, 32'h0);
      op(OP_READ_RESET, 32'h0, 32'h0);
      op(OP_POLL, 32'h0, 32'h0);
      chk("foreign command", rv[4], 0);
      op(OP_BLOCK_ERASE, 32'h10000, 32'h0);
      op(OP_HW_RESET, 32'h0, 32'h0);
      op(OP_POLL, 32'h0, 32'h0);
      chk("hw reset", rv[4], 0);
   endtask
   initial begin
      #400000;
      fails++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_abort();
      t_susp();
      t_chip(32'h0, 6);
      t_chip(32'h2, 2);
      t_block();
      end_sim();
   end
endmodule
bind nor_host_ctrl nor_host_props #(.RST_CYCLES(RST_CYCLES)) u_props (
   .clk_sys_i, .rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .flash_addr_o,
   .flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_rst_n_o);
`default_nettype wire

// file: hdl/nor_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module nor_bus_cycle #(
   parameter int SETUP = nor_host_pkg::SETUP_CYC,
   parameter int STROBE = nor_host_pkg::STROBE_CYC,
   parameter int HOLD = nor_host_pkg::HOLD_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic rd_i,
   input wire logic [nor_host_pkg::ADDR_W-1:0] addr_i,
   input wire logic [nor_host_pkg::DATA_W-1:0] wdata_i,
   output logic done_o,
   output logic [nor_host_pkg::DATA_W-1:0] rdata_o,
   output logic [nor_host_pkg::ADDR_W-1:0] addr_o,
   output logic [nor_host_pkg::DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [nor_host_pkg::DATA_W-1:0] dq_i,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o
);
   import nor_host_pkg::*;

   typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} cyc_e;
   typedef struct packed {
      cyc_e st;
      logic rd;
      logic [CNT_W-1:0] cnt;
      logic [DATA_W-1:0] sync1;
      logic [DATA_W-1:0] sync2;
      logic [DATA_W-1:0] rdata;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic done;
   } cyc_s;

   cyc_s q, next_q;

   always_comb begin
      next_q = q;
      next_q.done = 1'b0;
      next_q.sync1 = dq_i;
      next_q.sync2 = q.sync1;
      unique case (q.st)
         C_IDLE: begin
            if (req_i) begin
               next_q.st = C_SETUP;
               next_q.rd = rd_i;
               next_q.addr = addr_i;
               next_q.wdata = wdata_i;
               next_q.cnt = CNT_W'(SETUP - 1);
            end
         end
         C_SETUP: begin
            if (q.cnt == '0) begin
               next_q.st = C_STROBE;
               next_q.cnt = CNT_W'(STROBE - 1);
            end else begin
               next_q.cnt = q.cnt - 1'b1;
            end
         end
         C_STROBE: begin
            if (q.cnt == '0) begin
               next_q.st = C_HOLD;
               next_q.cnt = CNT_W'(HOLD - 1);
               if (q.rd) begin
                  next_q.rdata = q.sync2;
               end
            end else begin
               next_q.cnt = q.cnt - 1'b1;
            end
         end
         C_HOLD: begin
            if (q.cnt == '0) begin
               next_q.st = C_IDLE;
               next_q.done = 1'b1;
            end else begin
               next_q.cnt = q.cnt - 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign done_o = q.done;
   assign rdata_o = q.rdata;
   assign addr_o = q.addr;
   assign dq_o = q.wdata;
   // Data bus driven only for the whole of a write cycle, never on reads
   assign dq_oe_o = (q.st != C_IDLE) && !q.rd;
   assign ce_n_o = (q.st == C_IDLE);
   assign oe_n_o = !((q.st == C_STROBE) && q.rd);
   assign we_n_o = !((q.st == C_STROBE) && !q.rd);
endmodule
`default_nettype wire

// file: hdl/nor_host_ctrl.sv
// Behaviour
// R1 - Aborted buffer program: only abort-reset recovers (here OP_HW_RESET also clears the aborted state)
// R2 - Word count above buffer size aborts
// R3 - Load outside set-up block aborts
// R4 - Load outside starting buffer page aborts
// R5 - Non-confirm after last load aborts
// R6 - Abort status: flag set, toggling, no error
// R7 - Bypass mode still needs full three-cycle abort-reset
// R8 - Suspend command pauses programming, status updates
// R9 - Suspended: reads allowed, suspended address invalid
// R10 - Suspend also allowed inside erase suspend
// R11 - Identification mode returns to program suspend
// R12 - Resume restarts; extra resumes ignored
// R13 - High voltage on protect pin enters bypass
// R14 - Chip erase takes six write cycles
// R15 - Chip erase skips protected blocks silently
// R16 - During chip erase commands ignored, status read
// R17 - Chip erase error holds until read/reset
// R18 - Bypass chip erase takes two cycles
// R19 - Block erase six cycles, repeat sixth per block
// R20 - Selection timeout restarts; foreign command ends it
// R21 - Timer expiry shown on erase timer bit
// R22 - Protected selected blocks skipped, no error
// R23 - Block erase ignores commands; error needs read/reset
// R24 - Buffer holds at most 512 words
// R25 - Hardware reset abandons operation, back to read
`timescale 1ns/1ps
`default_nettype none
module nor_host_ctrl #(
   parameter int RST_CYCLES = nor_host_pkg::RST_CYC,
   parameter int BUF_MAX = nor_host_pkg::BUF_WORDS
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [nor_host_pkg::ADDR_W-1:0] flash_addr_o,
   output logic [nor_host_pkg::DATA_W-1:0] flash_dq_o,
   output logic flash_dq_oe_o,
   input wire logic [nor_host_pkg::DATA_W-1:0] flash_dq_i,
   output logic flash_ce_n_o,
   output logic flash_oe_n_o,
   output logic flash_we_n_o,
   output logic flash_rst_n_o,
   output logic high_voltage_level_o
);
   import nor_host_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_RESET} seq_e;
   typedef struct packed {
      seq_e st;
      op_e op;
      logic [3:0] step;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [1:0] mode;
      logic [CNT_W+4-1:0] rcnt;
      logic [DATA_W-1:0] rd0;
      logic [DATA_W-1:0] rd1;
      logic aborted;
      logic suspended;
      logic prog_active;
      logic chip_active;
      logic erase_active;
      logic err_pending;
      logic toggling;
      logic refused;
      logic [ADDR_W-PAGE_BITS-1:0] page;
      logic [9:0] load_left;
      logic loading;
      logic ack;
      logic [31:0] rdata;
   } ctl_s;

   ctl_s q, next_q;
   step_s cur;
   logic bypass;
   logic cyc_done;
   logic [DATA_W-1:0] cyc_rdata;
   logic allowed;
   logic [3:0] reg_idx;

   assign bypass = q.mode[MODE_BYPASS] || q.mode[MODE_VHH]; // see R13
   assign reg_idx = avs_address_i[5:2];

   // Bus step table for each operation
   always_comb begin
      cur = '0;
      unique case (q.op)
         OP_POLL: begin
            cur = '{q.step == 4'h1, 1'b1, q.addr, '0};
         end
         OP_WRITE: cur = '{1'b1, 1'b0, q.addr, q.data};
         OP_READ_RESET: cur = '{1'b1, 1'b0, q.addr, CMD_RESET};
         OP_ABORT_RESET: begin
            // Full three cycles even in bypass mode
            unique case (q.step) // see R1, R7
               4'h0: cur = '{1'b0, 1'b0, UNLOCK1_ADDR, UNLOCK1_DATA};
               4'h1: cur = '{1'b0, 1'b0, UNLOCK2_ADDR, UNLOCK2_DATA};
               default: cur = '{1'b1, 1'b0, UNLOCK1_ADDR, CMD_RESET};
            endcase
         end
         OP_SUSPEND: cur = '{1'b1, 1'b0, q.addr, CMD_SUSPEND}; // see R8, R10
         OP_RESUME: cur = '{1'b1, 1'b0, q.addr, CMD_RESUME}; // see R12
         OP_BLOCK_ADD: cur = '{1'b1, 1'b0, q.addr, CMD_BLOCK}; // see R19
         OP_CHIP_ERASE, OP_BLOCK_ERASE: begin
            if (bypass) begin
               // Two-cycle form in bypass mode
               cur = (q.step == 4'h0) ? '{1'b0, 1'b0, q.addr, CMD_ERASE_SETUP} : // see R18
                  (q.op == OP_CHIP_ERASE) ? '{1'b1, 1'b0, q.addr, CMD_CHIP} :
                  '{1'b1, 1'b0, q.addr, CMD_BLOCK};
            end else begin
               unique case (q.step) // see R14, R19
                  4'h0, 4'h3: cur = '{1'b0, 1'b0, UNLOCK1_ADDR, UNLOCK1_DATA};
                  4'h1, 4'h4: cur = '{1'b0, 1'b0, UNLOCK2_ADDR, UNLOCK2_DATA};
                  4'h2: cur = '{1'b0, 1'b0, UNLOCK1_ADDR, CMD_ERASE_SETUP};
                  default: cur = (q.op == OP_CHIP_ERASE) ?
                     '{1'b1, 1'b0, UNLOCK1_ADDR, CMD_CHIP} :
                     '{1'b1, 1'b0, q.addr, CMD_BLOCK};
               endcase
            end
         end
         OP_WBUF_SETUP: begin
            if (q.step == 4'h0 && !bypass) begin
               cur = '{1'b0, 1'b0, UNLOCK1_ADDR, UNLOCK1_DATA};
            end else if (q.step == 4'h1 && !bypass) begin
               cur = '{1'b0, 1'b0, UNLOCK2_ADDR, UNLOCK2_DATA};
            end else if ((bypass && q.step == 4'h0) || q.step == 4'h2) begin
               cur = '{1'b0, 1'b0, q.addr, CMD_WBUF};
            end else begin
               cur = '{1'b1, 1'b0, q.addr, q.data}; // Count n for n+1 words
            end
         end
         OP_WBUF_LOAD: cur = '{1'b1, 1'b0, q.addr, q.data};
         OP_WBUF_CONFIRM: cur = '{1'b1, 1'b0, q.addr, CMD_CONFIRM};
         OP_HW_RESET: cur = '{1'b1, 1'b0, q.addr, q.data};
         default: cur = '0;
      endcase
   end

   // Which new operation the device's current mode will take
   always_comb begin
      op_e req;
      logic [ADDR_W-PAGE_BITS-1:0] wpage;
      req = op_e'(avs_writedata_i[3:0]);
      wpage = q.addr[ADDR_W-1:PAGE_BITS];
      allowed = 1'b1;
      if (req == OP_POLL || req == OP_HW_RESET) begin
         allowed = 1'b1;
      end else if (q.aborted) begin
         allowed = (req == OP_ABORT_RESET); // see R1
      end else if (q.chip_active) begin
         allowed = 1'b0; // see R16
      end else if (q.err_pending) begin
         allowed = (req == OP_READ_RESET); // see R17, R23
      end else if (q.erase_active) begin
         // Adding blocks only before the selection timer expires
         allowed = (req == OP_SUSPEND) || (req == OP_READ_RESET) ||
            (req == OP_BLOCK_ADD && !q.rd1[ERASE_TIMER_BIT]); // see R20, R21, R23
      end else begin
         unique case (req)
            OP_RESUME: allowed = q.suspended; // see R12
            OP_SUSPEND: allowed = q.prog_active && !q.suspended; // see R8, R12
            OP_WBUF_SETUP: allowed = (32'(q.data) < 32'(BUF_MAX)); // see R2, R24
            OP_WBUF_LOAD: allowed = q.loading && (q.load_left != '0) &&
               (wpage == q.page); // see R3, R4
            OP_WBUF_CONFIRM: allowed = q.loading && (q.load_left == '0); // see R5
            OP_BLOCK_ADD: allowed = 1'b0;
            default: allowed = 1'b1;
         endcase
         // Only the confirm, a poll or a hardware reset may follow the last load
         if (q.loading && q.load_left == '0 && req != OP_WBUF_CONFIRM) begin
            allowed = 1'b0; // see R5
         end
      end
   end

   always_comb begin
      next_q = q;
      next_q.ack = 1'b0;
      // Register bus: one wait cycle, answer on the second
      if ((avs_read_i || avs_write_i) && !q.ack) begin
         next_q.ack = 1'b1;
         next_q.rdata = '0;
         if (avs_read_i) begin
            unique case (reg_idx)
               REG_CTRL: next_q.rdata = {28'h0, q.op};
               REG_ADDR: next_q.rdata = 32'(q.addr);
               REG_DATA: next_q.rdata = 32'(q.data);
               REG_MODE: next_q.rdata = {30'h0, q.mode};
               REG_STATUS: next_q.rdata = {22'h0, q.chip_active, q.refused,
                  q.rd1[ERASE_TIMER_BIT], q.rd1[ERROR_BIT], q.rd1[ABORT_FLAG_BIT],
                  q.toggling, q.erase_active, q.suspended, q.aborted, q.st != S_IDLE};
               REG_RDATA: next_q.rdata = 32'(q.rd1);
               default: next_q.rdata = '0;
            endcase
         end else begin
            unique case (reg_idx)
               REG_ADDR: next_q.addr = avs_writedata_i[ADDR_W-1:0];
               REG_DATA: next_q.data = avs_writedata_i[DATA_W-1:0];
               REG_MODE: next_q.mode = avs_writedata_i[1:0]; // see R13
               REG_CTRL: begin
                  if (q.st == S_IDLE && allowed) begin
                     next_q.op = op_e'(avs_writedata_i[3:0]);
                     next_q.step = '0;
                     next_q.refused = 1'b0;
                     next_q.st = (op_e'(avs_writedata_i[3:0]) == OP_HW_RESET) ?
                        S_RESET : S_ISSUE;
                     next_q.rcnt = '0;
                  end else begin
                     next_q.refused = 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end

      unique case (q.st)
         S_IDLE: ;
         S_ISSUE: next_q.st = S_WAIT;
         S_WAIT: begin
            if (cyc_done) begin
               if (cur.rd) begin
                  next_q.rd0 = q.rd1;
                  next_q.rd1 = cyc_rdata;
               end
               if (!cur.last) begin
                  next_q.step = q.step + 1'b1;
                  next_q.st = S_ISSUE;
               end else begin
                  next_q.st = S_IDLE;
                  unique case (q.op)
                     OP_POLL: begin
                        // Two reads: a moving toggle bit means still busy
                        next_q.toggling = q.rd1[TOGGLE_BIT] ^ cyc_rdata[TOGGLE_BIT];
                        if (next_q.toggling && cyc_rdata[ABORT_FLAG_BIT] &&
                            !cyc_rdata[ERROR_BIT]) begin
                           next_q.aborted = 1'b1; // see R6
                           next_q.prog_active = 1'b0;
                        end else if (!next_q.toggling && !q.suspended) begin
                           // Finished; protected blocks give no error
                           next_q.chip_active = 1'b0; // see R15, R22
                           next_q.erase_active = 1'b0;
                           next_q.prog_active = 1'b0;
                           next_q.err_pending = cyc_rdata[ERROR_BIT]; // see R17, R23
                        end
                     end
                     OP_ABORT_RESET: begin
                        next_q.aborted = 1'b0; // see R1
                        next_q.loading = 1'b0;
                     end
                     OP_READ_RESET: begin
                        next_q.err_pending = 1'b0; // see R17, R23
                        next_q.erase_active = 1'b0; // see R20
                        next_q.loading = 1'b0;
                     end
                     OP_SUSPEND: next_q.suspended = 1'b1; // see R8, R9, R10, R11
                     OP_RESUME: next_q.suspended = 1'b0; // see R12
                     OP_CHIP_ERASE: next_q.chip_active = 1'b1; // see R16
                     OP_BLOCK_ERASE: next_q.erase_active = 1'b1; // see R20
                     OP_WBUF_SETUP: begin
                        next_q.loading = 1'b1;
                        next_q.page = q.addr[ADDR_W-1:PAGE_BITS];
                        next_q.load_left = 10'(q.data) + 1'b1;
                     end
                     OP_WBUF_LOAD: next_q.load_left = q.load_left - 1'b1;
                     OP_WBUF_CONFIRM: begin
                        next_q.loading = 1'b0;
                        next_q.prog_active = 1'b1;
                     end
                     default: ;
                  endcase
               end
            end
         end
         S_RESET: begin
            // Pin reset abandons every operation in flight
            if (q.rcnt == (CNT_W+4)'(RST_CYCLES - 1)) begin // see R25
               next_q.st = S_IDLE;
               next_q.aborted = 1'b0;
               next_q.suspended = 1'b0;
               next_q.prog_active = 1'b0;
               next_q.chip_active = 1'b0;
               next_q.erase_active = 1'b0;
               next_q.err_pending = 1'b0;
               next_q.loading = 1'b0;
               next_q.toggling = 1'b0;
            end else begin
               next_q.rcnt = q.rcnt + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   nor_bus_cycle u_cycle (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .req_i(q.st == S_ISSUE),
      .rd_i(cur.rd),
      .addr_i(cur.a),
      .wdata_i(cur.d),
      .done_o(cyc_done),
      .rdata_o(cyc_rdata),
      .addr_o(flash_addr_o),
      .dq_o(flash_dq_o),
      .dq_oe_o(flash_dq_oe_o),
      .dq_i(flash_dq_i),
      .ce_n_o(flash_ce_n_o),
      .oe_n_o(flash_oe_n_o),
      .we_n_o(flash_we_n_o)
   );

   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !q.ack;
   assign avs_readdata_o = q.rdata;
   assign flash_rst_n_o = (q.st != S_RESET);
   assign high_voltage_level_o = q.mode[MODE_VHH]; // see R13
endmodule
`default_nettype wire

// file: hdl/nor_host_pkg.sv
package nor_host_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int CLK_MHZ = 125;
   // Bus cycle and reset pulse timing of the flash pins, in ns
   localparam int T_SETUP_NS = 10;
   localparam int T_STROBE_NS = 80;
   localparam int T_HOLD_NS = 20;
   localparam int T_RST_NS = 500;
   localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   // Two extra cycles cover the read-data synchroniser
   localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000 + 2;
   localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_CYC = (T_RST_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;

   // Command codes
   localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
   localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00b0;
   localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_WBUF = 16'h0025;
   localparam logic [DATA_W-1:0] CMD_CONFIRM = 16'h0029;
   localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
   localparam logic [DATA_W-1:0] CMD_CHIP = 16'h0010;
   localparam logic [DATA_W-1:0] CMD_BLOCK = 16'h0030;
   // Unlock cycles, plain defaults
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 24'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 24'h0002aa;
   localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
   localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;

   localparam int BUF_WORDS = 512;
   localparam int PAGE_BITS = 9;

   // Status word bit positions
   localparam int ABORT_FLAG_BIT = 1;
   localparam int ERASE_TIMER_BIT = 3;
   localparam int ERROR_BIT = 5;
   localparam int TOGGLE_BIT = 6;

   // Controller register word indices (avs_address_i[5:2])
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_DATA = 4'h2;
   localparam logic [3:0] REG_MODE = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RDATA = 4'h5;
   localparam int MODE_VHH = 0;
   localparam int MODE_BYPASS = 1;

   typedef enum logic [3:0] {
      OP_POLL, OP_WRITE, OP_READ_RESET, OP_ABORT_RESET, OP_SUSPEND, OP_RESUME,
      OP_CHIP_ERASE, OP_BLOCK_ERASE, OP_BLOCK_ADD, OP_WBUF_SETUP, OP_WBUF_LOAD,
      OP_WBUF_CONFIRM, OP_HW_RESET
   } op_e;

   typedef struct packed {
      logic last;
      logic rd;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
   } step_s;
endpackage
